// [bench/dplc_assertions.sv]
// Checker for the serial link and the DAC end outputs of the lockout block.
// Assumes one sys_clk_in domain; link wires are sampled on that clock.
`timescale 1ns/1ps
module dplc_assertions (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic frame_n,
	input wire logic lockout_pin_n,
	input wire logic async_clear_pin_n,
	input wire logic load_update_pin_n,
	input wire logic [15:0] dac_a_out,
	input wire logic [15:0] dac_b_out,
	input wire logic [1:0] power_mode_a_out,
	input wire logic [1:0] power_mode_b_out,
	input wire logic write_done_out,
	input wire logic write_aborted_out
);
	// ==========================================================
	// Clocking
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	// Both modes at normal, reused by several lockout checks
	wire logic modes_normal = (power_mode_a_out | power_mode_b_out) == 2'h0;

	// ==========================================================
	// Frame completion and abort
	property p_done_pulse; write_done_out |=> !write_done_out; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done wider than one cycle");
	property p_abort_quiet; write_aborted_out |-> !write_done_out; endproperty
	a_abort_quiet: assert property (p_abort_quiet) else $error("aborted frame executed");

	// ==========================================================
	// Lockout behaviour
	property p_lockout_clears; $fell(lockout_pin_n) |-> ##[1:6] modes_normal; endproperty
	a_lockout_clears: assert property (p_lockout_clears) else $error("modes kept");
	property p_lockout_holds; !lockout_pin_n [*8] |-> modes_normal; endproperty
	a_lockout_holds: assert property (p_lockout_holds) else $error("power-down in lockout");
	property p_release_normal; $rose(lockout_pin_n) |-> modes_normal [*8]; endproperty
	a_release_normal: assert property (p_release_normal) else $error("mode on release");
	// A mode change with lockout high must come from an executed frame
	property p_mode_by_cmd;
		($changed(power_mode_a_out) || $changed(power_mode_b_out)) && lockout_pin_n
			|-> write_done_out;
	endproperty
	a_mode_by_cmd: assert property (p_mode_by_cmd) else $error("mode change without frame");

	// ==========================================================
	// Clear pin and wire discipline
	property p_clear_code;
		$fell(async_clear_pin_n) |-> ##[2:6] (dac_a_out == dac_b_out
			&& dac_a_out inside {16'h0000, 16'h8000, 16'hFFFF});
	endproperty
	a_clear_code: assert property (p_clear_code) else $error("clear code not loaded");
	property p_clear_wakes;
		$fell(async_clear_pin_n) && !lockout_pin_n |-> ##[2:6] modes_normal;
	endproperty
	a_clear_wakes: assert property (p_clear_wakes) else $error("clear left power-down");
	property p_data_steady; $changed(sdata) |-> !sclk; endproperty
	a_data_steady: assert property (p_data_steady) else $error("data moved with clock high");
endmodule : dplc_assertions

// [bench/dplc_dac_end_tb.sv]
// Testbench: host end and DAC end joined over the link interface.
// Assumes the host end default serial half period; no partner model.
`timescale 1ns/1ps
module dplc_dac_end_tb;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic cmd_valid = 1'b0;
	logic [31:0] cmd_word = 32'h0;
	logic cmd_ready;
	logic lockout_n = 1'b1;
	logic clear_n = 1'b1;
	logic load_n = 1'b1;
	logic [15:0] dac_a, dac_b;
	logic [1:0] mode_a, mode_b;
	logic done, aborted;
	int miscompares = 0;
	int comparisons = 0;

	// ==========================================================
	// Design and checker
	dplc_link_if link_if();
	dplc_host_end dplc_host_end_i (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .link(link_if),
		.cmd_valid_in(cmd_valid), .cmd_word_in(cmd_word), .cmd_ready_out(cmd_ready),
		.lockout_n_in(lockout_n), .clear_n_in(clear_n), .load_n_in(load_n));
	dplc_dac_end dplc_dac_end_i (.sys_clk_in(sys_clk), .reset_n_in(reset_n), .link(link_if),
		.dac_a_out(dac_a), .dac_b_out(dac_b), .power_mode_a_out(mode_a),
		.power_mode_b_out(mode_b), .write_done_out(done), .write_aborted_out(aborted));
	dplc_assertions dplc_assertions_i (.sys_clk_in(sys_clk), .reset_n_in(reset_n),
		.sclk(link_if.sclk), .sdata(link_if.sdata), .frame_n(link_if.frame_n),
		.lockout_pin_n(link_if.lockout_pin_n), .async_clear_pin_n(link_if.async_clear_pin_n),
		.load_update_pin_n(link_if.load_update_pin_n), .dac_a_out(dac_a), .dac_b_out(dac_b),
		.power_mode_a_out(mode_a), .power_mode_b_out(mode_b), .write_done_out(done),
		.write_aborted_out(aborted));

	// ==========================================================
	// Helpers
	task automatic report_and_stop();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	function automatic logic [31:0] wr(input logic [3:0] cmd, input logic [3:0] addr,
		input logic [15:0] data);
		return {4'h0, cmd, addr, data, 4'h0};
	endfunction : wr
	function automatic logic [31:0] pwr(input logic [1:0] mode, input logic [1:0] sel);
		return {4'h0, dplc_pkg::CMD_POWER, 4'h0, 10'h000, mode, 4'h0, sel[1], 2'h0, sel[0]};
	endfunction : pwr
	// One command; cut > 0 drops lockout that many cycles into the frame
	task automatic send(input logic [31:0] word, input int cut);
		int n;
		n = 0;
		while (cmd_ready !== 1'b1 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		cmd_valid <= 1'b1;
		cmd_word <= word;
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
		if (cut > 0) begin
			repeat (cut) @(posedge sys_clk);
			lockout_n <= 1'b0;
			n = 0;
			while (aborted !== 1'b1 && n < 50) begin
				@(posedge sys_clk);
				n++;
			end
			chk("aborted", {15'h0000, aborted}, 16'h0001);
		end
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (done !== 1'b1 && n < 3000);
		chk("frame done", {15'h0000, done}, 16'h0001);
		repeat (4) @(posedge sys_clk);
	endtask : send
	// Pin levels, then time for the registered copy and the two-flop sampling
	task automatic pins(input logic lo, input logic cl, input logic ld);
		lockout_n <= lo;
		clear_n <= cl;
		load_n <= ld;
		repeat (10) @(posedge sys_clk);
	endtask : pins

	// ==========================================================
	// Clock and watchdog; a full run needs about 5000 cycles
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (40000) @(posedge sys_clk);
		miscompares++;
		report_and_stop();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		send(wr(dplc_pkg::CMD_WRITE_UPDATE, dplc_pkg::ADDR_A, 16'h1234), 0);
		chk("dac a", dac_a, 16'h1234);
		send(wr(dplc_pkg::CMD_WRITE_UPDATE, dplc_pkg::ADDR_B, 16'hABCD), 0);
		chk("dac b", dac_b, 16'hABCD);
		// Every termination on channel B only, channel A left alone
		for (int m = 1; m < 4; m++) begin
			send(pwr(m[1:0], 2'h2), 0);
			chk("mode b", {14'h0000, mode_b}, m[15:0]);
			chk("mode a", {14'h0000, mode_a}, 16'h0000);
		end
		send(pwr(2'h1, 2'h3), 0);
		chk("mode a", {14'h0000, mode_a}, 16'h0001);
		pins(1'b0, 1'b1, 1'b1);
		chk("modes", {12'h000, mode_a, mode_b}, 16'h0000);
		chk("dac a kept", dac_a, 16'h1234);
		send(pwr(2'h2, 2'h3), 0);
		chk("modes", {12'h000, mode_a, mode_b}, 16'h0000);
		pins(1'b1, 1'b1, 1'b1);
		chk("modes", {12'h000, mode_a, mode_b}, 16'h0000);
		send(pwr(2'h2, 2'h1), 0);
		chk("mode a", {14'h0000, mode_a}, 16'h0002);
		// Lockout falls mid-frame; the host resends the whole word
		send(wr(dplc_pkg::CMD_WRITE_UPDATE, dplc_pkg::ADDR_B, 16'h5555), 100);
		chk("dac b", dac_b, 16'h5555);
		chk("modes", {12'h000, mode_a, mode_b}, 16'h0000);
		pins(1'b1, 1'b1, 1'b1);
		send({4'h0, dplc_pkg::CMD_CLEAR_CODE, 4'h0, 18'h00000, dplc_pkg::CLEAR_SEL_MID}, 0);
		send(pwr(2'h3, 2'h3), 0);
		chk("modes", {12'h000, mode_a, mode_b}, 16'h000F);
		// Clear, lockout and load together; clear wins
		pins(1'b0, 1'b0, 1'b0);
		chk("dac a", dac_a, dplc_pkg::CLEAR_VAL_MID);
		chk("dac b", dac_b, dplc_pkg::CLEAR_VAL_MID);
		chk("modes", {12'h000, mode_a, mode_b}, 16'h0000);
		pins(1'b1, 1'b1, 1'b1);
		// Load pin high: writes wait; load falling or load low moves them over
		send(wr(dplc_pkg::CMD_WRITE_INPUT, dplc_pkg::ADDR_A, 16'h0F0F), 0);
		chk("dac a held", dac_a, dplc_pkg::CLEAR_VAL_MID);
		pins(1'b1, 1'b1, 1'b0);
		chk("dac a load", dac_a, 16'h0F0F);
		send(wr(dplc_pkg::CMD_WRITE_INPUT, dplc_pkg::ADDR_B, 16'h3C3C), 0);
		chk("dac b load low", dac_b, 16'h3C3C);
		pins(1'b1, 1'b1, 1'b1);
		// Update commands move input registers where addressed; write-update-all moves every channel
		send(wr(dplc_pkg::CMD_WRITE_INPUT, dplc_pkg::ADDR_ALL, 16'h7777), 0);
		chk("dac a held", dac_a, 16'h0F0F);
		send(wr(dplc_pkg::CMD_UPDATE_DAC, dplc_pkg::ADDR_A, 16'h0000), 0);
		chk("dac a upd", dac_a, 16'h7777);
		chk("dac b held", dac_b, 16'h3C3C);
		send(wr(dplc_pkg::CMD_WRITE_UPDATE_ALL, dplc_pkg::ADDR_B, 16'h1111), 0);
		chk("dac b all", dac_b, 16'h1111);
		chk("dac a all", dac_a, 16'h7777);
		report_and_stop();
	end
endmodule : dplc_dac_end_tb

// [hdl/dplc_dac_end.sv]
// DAC end: serial frame receiver, channel registers, power-down lockout.
// Assumes every link wire is asynchronous to sys_clk_in and slower than
// a quarter of its rate, so two-flop sampling resolves each edge.
`timescale 1ns/1ps
module dplc_dac_end (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	dplc_link_if.dac link,
	output logic [15:0] dac_a_out,
	output logic [15:0] dac_b_out,
	output logic [1:0] power_mode_a_out,
	output logic [1:0] power_mode_b_out,
	output logic write_done_out,
	output logic write_aborted_out
);

	// ==========================================================
	// Pin synchronisers
	logic [dplc_pkg::PIN_COUNT-1:0] pins_raw;
	logic [dplc_pkg::PIN_COUNT-1:0] meta_r;
	logic [dplc_pkg::PIN_COUNT-1:0] sync_r;
	logic [dplc_pkg::PIN_COUNT-1:0] prev_r;

	assign pins_raw[dplc_pkg::PIN_SCLK] = link.sclk;
	assign pins_raw[dplc_pkg::PIN_SDATA] = link.sdata;
	assign pins_raw[dplc_pkg::PIN_FRAME_N] = link.frame_n;
	assign pins_raw[dplc_pkg::PIN_LOCKOUT_N] = link.lockout_pin_n;
	assign pins_raw[dplc_pkg::PIN_CLEAR_N] = link.async_clear_pin_n;
	assign pins_raw[dplc_pkg::PIN_LOAD_N] = link.load_update_pin_n;

	// Two flops per pin; only the second stage and its delayed copy feed logic
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta_r <= dplc_pkg::PIN_IDLE;
			sync_r <= dplc_pkg::PIN_IDLE;
			prev_r <= dplc_pkg::PIN_IDLE;
		end else begin
			meta_r <= pins_raw;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// ==========================================================
	// Edge and level decode
	wire s_frame_n = sync_r[dplc_pkg::PIN_FRAME_N];
	wire s_sdata = sync_r[dplc_pkg::PIN_SDATA];
	wire s_lock_n = sync_r[dplc_pkg::PIN_LOCKOUT_N];
	wire s_load_n = sync_r[dplc_pkg::PIN_LOAD_N];
	wire sclk_rise = sync_r[dplc_pkg::PIN_SCLK] & ~prev_r[dplc_pkg::PIN_SCLK];
	wire sclk_fall = ~sync_r[dplc_pkg::PIN_SCLK] & prev_r[dplc_pkg::PIN_SCLK];
	// Edges come from synchronised copies, so a runt pulse cannot split decisions
	wire lock_fall = ~s_lock_n & prev_r[dplc_pkg::PIN_LOCKOUT_N];
	wire clear_fall = ~sync_r[dplc_pkg::PIN_CLEAR_N] & prev_r[dplc_pkg::PIN_CLEAR_N];
	wire load_fall = ~s_load_n & prev_r[dplc_pkg::PIN_LOAD_N];
	wire abort_now = lock_fall | clear_fall;

	// ==========================================================
	// Frame receiver state
	logic [31:0] shift_r;
	logic [5:0] bitcnt_r;
	logic armed_r;
	logic aborted_r;
	logic done_r;

	wire frame_full = (bitcnt_r == dplc_pkg::FRAME_BITS);
	wire take_bit = armed_r & ~s_frame_n & sclk_rise & ~frame_full & ~abort_now;
	// Execute on the falling serial edge that follows the 32nd rising one
	wire exec = armed_r & ~s_frame_n & sclk_fall & frame_full & ~abort_now;

	// Shift in MSB first; frame select high rearms, an abort while frame select is low disarms
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			shift_r <= 32'h0000_0000;
			bitcnt_r <= 6'h00;
			armed_r <= 1'b0;
			aborted_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= exec;
			if (s_frame_n) begin
				bitcnt_r <= 6'h00;
				armed_r <= 1'b1;
				aborted_r <= 1'b0;
			end else if (abort_now && armed_r) begin
				armed_r <= 1'b0;
				aborted_r <= 1'b1;
			end else if (take_bit) begin
				shift_r <= {shift_r[30:0], s_sdata};
				bitcnt_r <= bitcnt_r + 6'h01;
			end else if (exec) begin
				armed_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Command field decode
	wire [3:0] cmd = shift_r[dplc_pkg::CMD_HI:dplc_pkg::CMD_LO];
	wire [3:0] addr = shift_r[dplc_pkg::ADDR_HI:dplc_pkg::ADDR_LO];
	wire [15:0] wdata = shift_r[dplc_pkg::DATA_HI:dplc_pkg::DATA_LO];
	wire [1:0] mode_req = {shift_r[dplc_pkg::POWER_MODE_HI_BIT],
		shift_r[dplc_pkg::POWER_MODE_LO_BIT]};
	wire [1:0] clear_sel_req = {shift_r[dplc_pkg::CLEAR_SELECT_HI_BIT],
		shift_r[dplc_pkg::CLEAR_SELECT_LO_BIT]};
	wire is_write = exec & (cmd == dplc_pkg::CMD_WRITE_INPUT
		| cmd == dplc_pkg::CMD_WRITE_UPDATE | cmd == dplc_pkg::CMD_WRITE_UPDATE_ALL);
	wire is_wr_upd = exec & (cmd == dplc_pkg::CMD_WRITE_UPDATE);
	wire is_upd_all = exec & (cmd == dplc_pkg::CMD_WRITE_UPDATE_ALL);
	wire is_update = exec & (cmd == dplc_pkg::CMD_UPDATE_DAC);
	// Lockout low gates power-down off; release lets it through once the synchronised level is high
	wire is_power = exec & (cmd == dplc_pkg::CMD_POWER) & s_lock_n;
	wire is_code = exec & (cmd == dplc_pkg::CMD_CLEAR_CODE);

	// Channel address match and power-down select bits
	logic [dplc_pkg::NUM_CHANNELS-1:0] addr_hit;
	logic [dplc_pkg::NUM_CHANNELS-1:0] pd_sel;
	assign addr_hit[0] = (addr == dplc_pkg::ADDR_A) | (addr == dplc_pkg::ADDR_ALL);
	assign addr_hit[1] = (addr == dplc_pkg::ADDR_B) | (addr == dplc_pkg::ADDR_ALL);
	assign pd_sel[0] = shift_r[dplc_pkg::SEL_A_BIT];
	assign pd_sel[1] = shift_r[dplc_pkg::SEL_B_BIT];

	// ==========================================================
	// Clear code register and its value
	logic [1:0] clear_sel_r;
	logic [15:0] clear_val;
	wire clear_active = clear_fall & (clear_sel_r != dplc_pkg::CLEAR_SEL_NOP);

	// Selection of the clear value; the no-op code leaves registers alone
	always_comb begin
		case (clear_sel_r)
			dplc_pkg::CLEAR_SEL_ZERO: clear_val = dplc_pkg::CLEAR_VAL_ZERO;
			dplc_pkg::CLEAR_SEL_MID: clear_val = dplc_pkg::CLEAR_VAL_MID;
			dplc_pkg::CLEAR_SEL_FULL: clear_val = dplc_pkg::CLEAR_VAL_FULL;
			default: clear_val = dplc_pkg::CLEAR_VAL_ZERO;
		endcase
	end

	// Clear code only changes by its own command
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			clear_sel_r <= dplc_pkg::CLEAR_SEL_ZERO;
		end else if (is_code) begin
			clear_sel_r <= clear_sel_req;
		end
	end

	// ==========================================================
	// Per-channel input, DAC and power-mode registers
	logic [15:0] input_r [dplc_pkg::NUM_CHANNELS];
	logic [15:0] dac_r [dplc_pkg::NUM_CHANNELS];
	logic [1:0] pmode_r [dplc_pkg::NUM_CHANNELS];

	genvar ch;
	generate
		for (ch = 0; ch < dplc_pkg::NUM_CHANNELS; ch++) begin : g_chan
			wire wr_hit = is_write & addr_hit[ch];
			// Load low updates at frame end; load falling edge copies input over
			wire upd_sync = (is_wr_upd & addr_hit[ch]) | is_upd_all
				| (is_update & addr_hit[ch]) | (wr_hit & ~s_load_n);
			wire [15:0] next_in = wr_hit ? wdata : input_r[ch];

			// Clear first, then lockout, then ordinary commands and load
			always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					input_r[ch] <= dplc_pkg::CLEAR_VAL_ZERO;
					dac_r[ch] <= dplc_pkg::CLEAR_VAL_ZERO;
					pmode_r[ch] <= dplc_pkg::POWER_NORMAL;
				end else if (clear_fall) begin
					if (clear_active) begin
						input_r[ch] <= clear_val;
						dac_r[ch] <= clear_val;
					end
					if (!s_lock_n) begin
						pmode_r[ch] <= dplc_pkg::POWER_NORMAL;
					end
				end else if (lock_fall) begin
					// Output resumes at the held DAC value; nothing else moves
					pmode_r[ch] <= dplc_pkg::POWER_NORMAL;
				end else begin
					input_r[ch] <= next_in;
					if (upd_sync || load_fall) begin
						dac_r[ch] <= next_in;
					end
					if (is_power && pd_sel[ch]) begin
						pmode_r[ch] <= mode_req;
					end
				end
			end
		end
	endgenerate

	// Lockout release leaves modes untouched: no saved state is restored

	// ==========================================================
	// Outputs
	assign dac_a_out = dac_r[0];
	assign dac_b_out = dac_r[1];
	assign power_mode_a_out = pmode_r[0];
	assign power_mode_b_out = pmode_r[1];
	assign write_done_out = done_r;
	assign write_aborted_out = aborted_r;

endmodule : dplc_dac_end

// [hdl/dplc_host_end.sv]
// Host end: shifts 32-bit commands out over the serial link and drives
// the lockout, clear and load pins from user-side levels.
// Assumes user inputs are on sys_clk_in; the serial clock is divided down.
`timescale 1ns/1ps
module dplc_host_end #(
	parameter int HALF_CYC = dplc_pkg::SCLK_HALF_CYC
) (
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	dplc_link_if.host link,
	input wire logic cmd_valid_in,
	input wire logic [31:0] cmd_word_in,
	output logic cmd_ready_out,
	input wire logic lockout_n_in,
	input wire logic clear_n_in,
	input wire logic load_n_in
);

	// ==========================================================
	// State and pin registers
	dplc_pkg::dplc_host_state_t state_r;
	logic [7:0] div_r;
	logic sclk_r;
	logic frame_n_r;
	logic [31:0] shift_r;
	logic [31:0] word_r;
	logic [5:0] bits_r;
	logic resend_r;
	logic lock_n_r;
	logic clear_n_r;
	logic load_n_r;

	wire tick = (div_r == 8'(HALF_CYC - 1));
	// Lockout or clear falling mid-frame kills the frame on the far side
	wire kill = (lock_n_r & ~lockout_n_in) | (clear_n_r & ~clear_n_in);

	// ==========================================================
	// Serial sequencer: sclk idles low, data changes on falling edges
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= dplc_pkg::DPLC_IDLE;
			div_r <= 8'h00;
			sclk_r <= 1'b0;
			frame_n_r <= 1'b1;
			shift_r <= 32'h0000_0000;
			word_r <= 32'h0000_0000;
			bits_r <= 6'h00;
			resend_r <= 1'b0;
			lock_n_r <= 1'b1;
			clear_n_r <= 1'b1;
			load_n_r <= 1'b1;
		end else begin
			lock_n_r <= lockout_n_in;
			clear_n_r <= clear_n_in;
			load_n_r <= load_n_in;
			div_r <= tick ? 8'h00 : div_r + 8'h01;
			case (state_r)
				dplc_pkg::DPLC_IDLE: begin
					div_r <= 8'h00;
					if (cmd_valid_in) begin
						word_r <= cmd_word_in;
						shift_r <= cmd_word_in;
						frame_n_r <= 1'b0;
						bits_r <= 6'h00;
						state_r <= dplc_pkg::DPLC_SHIFT;
					end
				end
				dplc_pkg::DPLC_SHIFT: begin
					if (kill) begin
						// Frame select stays low one half period so the far end
						// sees the abort before the frame closes; then a resend
						sclk_r <= 1'b0;
						resend_r <= 1'b1;
						div_r <= 8'h00;
						state_r <= dplc_pkg::DPLC_GAP;
					end else if (tick && !sclk_r) begin
						sclk_r <= 1'b1;
						bits_r <= bits_r + 6'h01;
					end else if (tick) begin
						sclk_r <= 1'b0;
						shift_r <= {shift_r[30:0], 1'b0};
						if (bits_r == dplc_pkg::FRAME_BITS) begin
							resend_r <= 1'b0;
							state_r <= dplc_pkg::DPLC_GAP;
						end
					end
				end
				dplc_pkg::DPLC_GAP: begin
					// Frame select stays low for all 32 bits, rises only here
					if (tick && !frame_n_r) begin
						frame_n_r <= 1'b1;
					end else if (tick && resend_r) begin
						shift_r <= word_r;
						frame_n_r <= 1'b0;
						bits_r <= 6'h00;
						resend_r <= 1'b0;
						state_r <= dplc_pkg::DPLC_SHIFT;
					end else if (tick) begin
						state_r <= dplc_pkg::DPLC_IDLE;
					end
				end
				default: state_r <= dplc_pkg::DPLC_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Pin drive
	assign link.sclk = sclk_r;
	assign link.sdata = shift_r[31];
	assign link.frame_n = frame_n_r;
	assign link.lockout_pin_n = lock_n_r;
	assign link.async_clear_pin_n = clear_n_r;
	assign link.load_update_pin_n = load_n_r;
	assign cmd_ready_out = (state_r == dplc_pkg::DPLC_IDLE);

endmodule : dplc_host_end

// [hdl/dplc_link_if.sv]
// Three-wire serial link plus the lockout, clear and load pins.
// Host end drives every wire; the DAC end only listens.
`timescale 1ns/1ps
interface dplc_link_if;
	logic sclk;
	logic sdata;
	logic frame_n;
	logic lockout_pin_n;
	logic async_clear_pin_n;
	logic load_update_pin_n;

	// ==========================================================
	// Party views
	modport dac (input sclk, input sdata, input frame_n, input lockout_pin_n,
		input async_clear_pin_n, input load_update_pin_n);
	modport host (output sclk, output sdata, output frame_n, output lockout_pin_n,
		output async_clear_pin_n, output load_update_pin_n);
endinterface : dplc_link_if

// [hdl/dplc_pkg.sv]
// Shared constants for the DAC power-down lockout controller and its host.
// Assumes a single 200 MHz system clock on both ends of the serial link.
package dplc_pkg;

	// ==========================================================
	// Serial frame layout
	localparam logic [5:0] FRAME_BITS = 6'h20;
	localparam int CMD_HI = 27;
	localparam int CMD_LO = 24;
	localparam int ADDR_HI = 23;
	localparam int ADDR_LO = 20;
	localparam int DATA_HI = 19;
	localparam int DATA_LO = 4;
	localparam int POWER_MODE_HI_BIT = 9;
	localparam int POWER_MODE_LO_BIT = 8;
	localparam int SEL_B_BIT = 3;
	localparam int SEL_A_BIT = 0;
	localparam int CLEAR_SELECT_HI_BIT = 1;
	localparam int CLEAR_SELECT_LO_BIT = 0;
	localparam int DAC_WIDTH = 16;
	localparam int NUM_CHANNELS = 2;

	// ==========================================================
	// Commands and channel addresses
	localparam logic [3:0] CMD_WRITE_INPUT = 4'h0;
	localparam logic [3:0] CMD_UPDATE_DAC = 4'h1;
	localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h2;
	localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
	localparam logic [3:0] CMD_POWER = 4'h4;
	localparam logic [3:0] CMD_CLEAR_CODE = 4'h5;
	localparam logic [3:0] ADDR_A = 4'h0;
	localparam logic [3:0] ADDR_B = 4'h1;
	localparam logic [3:0] ADDR_ALL = 4'hF;

	// ==========================================================
	// Power modes and clear codes
	localparam logic [1:0] POWER_NORMAL = 2'h0;
	localparam logic [1:0] CLEAR_SEL_ZERO = 2'h0;
	localparam logic [1:0] CLEAR_SEL_MID = 2'h1;
	localparam logic [1:0] CLEAR_SEL_FULL = 2'h2;
	localparam logic [1:0] CLEAR_SEL_NOP = 2'h3;
	localparam logic [15:0] CLEAR_VAL_ZERO = 16'h0000;
	localparam logic [15:0] CLEAR_VAL_MID = 16'h8000;
	localparam logic [15:0] CLEAR_VAL_FULL = 16'hFFFF;

	// ==========================================================
	// Pin synchroniser slots, idle levels after reset
	localparam int PIN_SCLK = 0;
	localparam int PIN_SDATA = 1;
	localparam int PIN_FRAME_N = 2;
	localparam int PIN_LOCKOUT_N = 3;
	localparam int PIN_CLEAR_N = 4;
	localparam int PIN_LOAD_N = 5;
	localparam int PIN_COUNT = 6;
	localparam logic [5:0] PIN_IDLE = 6'h3C;

	// ==========================================================
	// Timing: serial clock half period
	localparam int CLK_PERIOD_PS = 5000;
	localparam int SCLK_HALF_NS = 20;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	typedef enum logic [1:0] {DPLC_IDLE, DPLC_SHIFT, DPLC_GAP} dplc_host_state_t;

endpackage : dplc_pkg
